// File: rtl/ftca_pkg.sv
// Shared constants, register map and stream types of the frame trailer appender
package ftca_pkg;

  // Register byte offsets
  localparam logic [7:0] FTCA_REG_CTRL      = 8'h00; // Trailer framing master switch
  localparam logic [7:0] FTCA_REG_PICK      = 8'h04; // Optional item selector
  localparam logic [7:0] FTCA_REG_ITEM_ON   = 8'h08; // Enable of picked item
  localparam logic [7:0] FTCA_REG_X_START   = 8'h0c; // Region horizontal start
  localparam logic [7:0] FTCA_REG_WIDTH     = 8'h10; // Region width
  localparam logic [7:0] FTCA_REG_HEIGHT    = 8'h14; // Region height
  localparam logic [7:0] FTCA_REG_FORMAT    = 8'h18; // Sample format code
  localparam logic [7:0] FTCA_REG_RANGE_LO  = 8'h1c; // Dynamic range low
  localparam logic [7:0] FTCA_REG_RANGE_HI  = 8'h20; // Dynamic range high
  localparam logic [7:0] FTCA_REG_FRAME_CNT = 8'h24; // Acquired frames, read only
  localparam logic [7:0] FTCA_REG_TS_LO     = 8'h28; // Time stamp low word, read only
  localparam logic [7:0] FTCA_REG_TS_HI     = 8'h2c; // Time stamp high word, read only
  localparam logic [7:0] FTCA_REG_STATUS    = 8'h30; // Live state, read only

  // Field layouts
  localparam int FTCA_FIELD_W     = 16;  // Region and range field width
  localparam int FTCA_ITEMS       = 2;   // Selectable optional items
  localparam int FTCA_FC_W        = 32;  // Frame counter width
  localparam int FTCA_TS_W        = 64;  // Time stamp width
  localparam logic [0:0] FTCA_PICK_FRAME_CNT = 1'h0; // Item code: frame counter
  localparam logic [0:0] FTCA_PICK_TSTAMP    = 1'h1; // Item code: time stamp

  // Reset values
  localparam logic [15:0] FTCA_RST_FIELD  = 16'h0000;
  localparam logic [31:0] FTCA_RST_FORMAT = 32'h0000_0000;

  // Payload kinds advertised to the receiver
  localparam logic [1:0] FTCA_KIND_IMAGE   = 2'h1; // Plain image
  localparam logic [1:0] FTCA_KIND_TRAILER = 2'h2; // Image with trailing chunks

  // Chunk identifiers, arbitrary values
  localparam logic [15:0] FTCA_ID_EXT = 16'ha001;
  localparam logic [15:0] FTCA_ID_FC  = 16'ha002;
  localparam logic [15:0] FTCA_ID_TS  = 16'ha003;

  // Chunk payload lengths in bytes
  localparam logic [15:0] FTCA_LEN_EXT = 16'h0018;
  localparam logic [15:0] FTCA_LEN_FC  = 16'h0004;
  localparam logic [15:0] FTCA_LEN_TS  = 16'h0008;

  // Trailer word slots: extended data 0..6, counter 7..8, stamp 9..11
  localparam logic [3:0] FTCA_SLOT_EXT_HDR = 4'h0;
  localparam logic [3:0] FTCA_SLOT_EXT_END = 4'h6;
  localparam logic [3:0] FTCA_SLOT_FC_HDR  = 4'h7;
  localparam logic [3:0] FTCA_SLOT_FC_END  = 4'h8;
  localparam logic [3:0] FTCA_SLOT_TS_HDR  = 4'h9;
  localparam logic [3:0] FTCA_SLOT_TS_END  = 4'hb;

  // Time stamp tick: 8 ns per tick at a 5 ns clock
  localparam int FTCA_TICK_NS   = 8;
  localparam int FTCA_CLK_PS    = 5000;
  localparam int FTCA_CLK_NS    = FTCA_CLK_PS / 1000;
  localparam logic [3:0] FTCA_ACC_STEP = 4'(FTCA_CLK_NS);
  localparam logic [3:0] FTCA_ACC_WRAP = 4'(FTCA_TICK_NS);

  // Trailer state machine
  typedef enum logic [1:0] {
    FTCA_IMAGE   = 2'b01,
    FTCA_TRAILER = 2'b10
  } ftca_state_e;

  // One stream beat
  typedef struct packed {
    logic [31:0] data;
    logic        last;
  } ftca_beat_s;

endpackage

// File: rtl/ftca_tstamp.sv
// Free-running time stamp counter ticking every 8 ns
`timescale 1ns/100ps
module ftca_tstamp import ftca_pkg::*; (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  output logic      [FTCA_TS_W-1:0] count
);

  logic [3:0] acc; // Nanoseconds carried toward the next tick

  // Fractional accumulator: the clock period does not divide the tick,
  // so ticks land on a 5/8 duty pattern with no long-term drift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc   <= 4'h0;
      count <= 64'h0000_0000_0000_0000;
    end else if (acc + FTCA_ACC_STEP >= FTCA_ACC_WRAP) begin
      acc   <= 4'(acc + FTCA_ACC_STEP - FTCA_ACC_WRAP);
      count <= count + 64'h0000_0000_0000_0001; // Counts from reset
    end else begin
      acc   <= 4'(acc + FTCA_ACC_STEP);
    end
  end

endmodule // ftca_tstamp

// File: rtl/ftca_appender.sv
// Frame trailer appender: passes image words and appends per-frame chunks
//
// What this block does
// - Master switch on enables extended-data chunk automatically
// - Item enables only take while switch on
// - Switch off disables every chunk feature
// - Switch changes advertised payload kind
// - Extended chunk carries offset, width, height
// - Extended chunk carries format and range limits
// - Chunks follow image data in same frame
// - Frame counter value sampled into its chunk
// - Time stamp of acquisition attached per frame
// - Frame counter 32-bit, from zero, wraps
// - Time stamp 64-bit free-running since reset
// - Each time stamp tick is 8 ns
// - Items enabled via selector then enable
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module ftca_appender import ftca_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Image stream from the acquisition pipeline
  input  wire ftca_beat_s  in_beat,
  input  wire logic        in_valid,
  output logic             in_ready,
  // Frame stream toward the host transmitter
  output ftca_beat_s       out_beat,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [1:0]       payload_kind
);

  // Software settings
  logic                    trailer_framing_on;     // Master switch
  logic [0:0]              trailer_item_pick;      // Selected item
  logic [FTCA_ITEMS-1:0]   item_on;                // Per-item enables
  logic [FTCA_FIELD_W-1:0] trailer_region_x_start;
  logic [FTCA_FIELD_W-1:0] trailer_region_width;
  logic [FTCA_FIELD_W-1:0] trailer_region_height;
  logic [31:0]             trailer_sample_format;
  logic [FTCA_FIELD_W-1:0] trailer_range_low;
  logic [FTCA_FIELD_W-1:0] trailer_range_high;

  // Per-frame snapshot, frozen at the first image word; counter value at the last
  logic                    snap_ext;    // Extended chunk for this frame
  logic                    snap_fc;     // Counter chunk for this frame
  logic                    snap_ts;     // Stamp chunk for this frame
  logic [FTCA_FIELD_W-1:0] snap_x;
  logic [FTCA_FIELD_W-1:0] snap_w;
  logic [FTCA_FIELD_W-1:0] snap_h;
  logic [31:0]             snap_fmt;
  logic [FTCA_FIELD_W-1:0] snap_lo;
  logic [FTCA_FIELD_W-1:0] snap_hi;
  logic [FTCA_TS_W-1:0]    snap_ts_val;
  logic [FTCA_FC_W-1:0]    snap_fc_val;

  logic [FTCA_FC_W-1:0]    frame_cnt;   // Acquired frames
  logic [FTCA_TS_W-1:0]    ts_now;      // Live time stamp
  ftca_state_e             state;       // Image or trailer phase
  logic [3:0]              slot;        // Current trailer word slot
  logic [3:0]              next_slot;   // Slot after this one
  logic                    slot_final;  // Current slot ends the trailer
  logic [31:0]             slot_word;   // Word for current slot
  logic                    first_word;  // Next image word opens a frame
  logic                    load;        // Output register free
  logic                    in_take;     // Image word accepted
  logic                    apb_wr;      // APB write access
  logic                    apb_rd;      // APB read setup cycle
  logic                    addr_ok;     // Address is mapped

  ftca_tstamp u_tstamp (
    .pclk    (pclk),
    .presetn (presetn),
    .count   (ts_now)
  );

  // APB answers in its first access cycle, never waits
  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;

  // Address decode
  always_comb begin
    case (paddr)
      FTCA_REG_CTRL, FTCA_REG_PICK, FTCA_REG_ITEM_ON, FTCA_REG_X_START,
      FTCA_REG_WIDTH, FTCA_REG_HEIGHT, FTCA_REG_FORMAT, FTCA_REG_RANGE_LO,
      FTCA_REG_RANGE_HI, FTCA_REG_FRAME_CNT, FTCA_REG_TS_LO, FTCA_REG_TS_HI,
      FTCA_REG_STATUS: addr_ok = 1'b1;
      default:         addr_ok = 1'b0;
    endcase
  end

  // Unmapped address errors; read-only writes are simply dropped
  assign pslverr = psel && penable && !addr_ok;

  // Master switch and item selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trailer_framing_on <= 1'b0;
      trailer_item_pick  <= FTCA_PICK_FRAME_CNT;
      item_on            <= '0;
    end else if (apb_wr) begin
      if (paddr == FTCA_REG_CTRL) begin
        trailer_framing_on <= pwdata[0];
        if (!pwdata[0]) begin
          item_on <= '0;
        end
      end else if (paddr == FTCA_REG_PICK) begin
        trailer_item_pick <= pwdata[0:0];
      end else if (paddr == FTCA_REG_ITEM_ON && trailer_framing_on) begin
        item_on[trailer_item_pick] <= pwdata[0];
      end
    end
  end

  // Region, format and range settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trailer_region_x_start <= FTCA_RST_FIELD;
      trailer_region_width   <= FTCA_RST_FIELD;
      trailer_region_height  <= FTCA_RST_FIELD;
      trailer_sample_format  <= FTCA_RST_FORMAT;
      trailer_range_low      <= FTCA_RST_FIELD;
      trailer_range_high     <= FTCA_RST_FIELD;
    end else if (apb_wr) begin
      case (paddr)
        FTCA_REG_X_START:  trailer_region_x_start <= pwdata[FTCA_FIELD_W-1:0];
        FTCA_REG_WIDTH:    trailer_region_width   <= pwdata[FTCA_FIELD_W-1:0];
        FTCA_REG_HEIGHT:   trailer_region_height  <= pwdata[FTCA_FIELD_W-1:0];
        FTCA_REG_FORMAT:   trailer_sample_format  <= pwdata;
        FTCA_REG_RANGE_LO: trailer_range_low      <= pwdata[FTCA_FIELD_W-1:0];
        FTCA_REG_RANGE_HI: trailer_range_high     <= pwdata[FTCA_FIELD_W-1:0];
        default: ;
      endcase
    end
  end

  // Read mux, registered so prdata comes from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      case (paddr)
        FTCA_REG_CTRL:      prdata <= {31'h0, trailer_framing_on};
        FTCA_REG_PICK:      prdata <= {31'h0, trailer_item_pick};
        FTCA_REG_ITEM_ON:   prdata <= {31'h0, item_on[trailer_item_pick]};
        FTCA_REG_X_START:   prdata <= {16'h0, trailer_region_x_start};
        FTCA_REG_WIDTH:     prdata <= {16'h0, trailer_region_width};
        FTCA_REG_HEIGHT:    prdata <= {16'h0, trailer_region_height};
        FTCA_REG_FORMAT:    prdata <= trailer_sample_format;
        FTCA_REG_RANGE_LO:  prdata <= {16'h0, trailer_range_low};
        FTCA_REG_RANGE_HI:  prdata <= {16'h0, trailer_range_high};
        FTCA_REG_FRAME_CNT: prdata <= frame_cnt;
        FTCA_REG_TS_LO:     prdata <= ts_now[31:0];
        FTCA_REG_TS_HI:     prdata <= ts_now[63:32];
        FTCA_REG_STATUS:    prdata <= {28'h0, payload_kind, state};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Advertised payload kind follows the master switch live
  assign payload_kind = trailer_framing_on ? FTCA_KIND_TRAILER : FTCA_KIND_IMAGE;

  // Output register handshake
  assign load     = !out_valid || out_ready;
  assign in_ready = load && (state == FTCA_IMAGE);
  assign in_take  = in_valid && in_ready;

  // Frame-open tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_word <= 1'b1;
    end else if (in_take) begin
      first_word <= in_beat.last;
    end
  end

  // Acquired frame counter, wraps naturally at its width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt <= 32'h0000_0000;
    end else if (in_take && in_beat.last) begin
      frame_cnt <= frame_cnt + 32'h0000_0001;
    end
  end

  // Snapshot at frame open so a frame's trailer is self-consistent even if
  // software rewrites settings mid-frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_ext    <= 1'b0;
      snap_fc     <= 1'b0;
      snap_ts     <= 1'b0;
      snap_x      <= FTCA_RST_FIELD;
      snap_w      <= FTCA_RST_FIELD;
      snap_h      <= FTCA_RST_FIELD;
      snap_fmt    <= FTCA_RST_FORMAT;
      snap_lo     <= FTCA_RST_FIELD;
      snap_hi     <= FTCA_RST_FIELD;
      snap_ts_val <= 64'h0000_0000_0000_0000;
    end else if (in_take && first_word) begin
      snap_ext    <= trailer_framing_on;
      snap_fc     <= trailer_framing_on && item_on[FTCA_PICK_FRAME_CNT];
      snap_ts     <= trailer_framing_on && item_on[FTCA_PICK_TSTAMP];
      snap_x      <= trailer_region_x_start;
      snap_w      <= trailer_region_width;
      snap_h      <= trailer_region_height;
      snap_fmt    <= trailer_sample_format;
      snap_lo     <= trailer_range_low;
      snap_hi     <= trailer_range_high;
      snap_ts_val <= ts_now;
    end
  end

  // Counter value sampled at the frame's last word, before it counts this frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_fc_val <= 32'h0000_0000;
    end else if (in_take && in_beat.last) begin
      snap_fc_val <= frame_cnt;
    end
  end

  // Trailer word contents per slot, each chunk opened by id and length
  always_comb begin
    case (slot)
      4'h0:    slot_word = {FTCA_ID_EXT, FTCA_LEN_EXT};
      4'h1:    slot_word = {16'h0, snap_x};
      4'h2:    slot_word = {16'h0, snap_w};
      4'h3:    slot_word = {16'h0, snap_h};
      4'h4:    slot_word = snap_fmt;
      4'h5:    slot_word = {16'h0, snap_lo};
      4'h6:    slot_word = {16'h0, snap_hi};
      4'h7:    slot_word = {FTCA_ID_FC, FTCA_LEN_FC};
      4'h8:    slot_word = snap_fc_val;
      4'h9:    slot_word = {FTCA_ID_TS, FTCA_LEN_TS};
      4'ha:    slot_word = snap_ts_val[31:0];
      4'hb:    slot_word = snap_ts_val[63:32];
      default: slot_word = 32'h0000_0000;
    endcase
  end

  // Slot sequencing skips disabled chunks
  always_comb begin
    next_slot  = slot + 4'h1;
    slot_final = 1'b0;
    if (slot == FTCA_SLOT_EXT_END) begin
      next_slot  = snap_fc ? FTCA_SLOT_FC_HDR : FTCA_SLOT_TS_HDR;
      slot_final = !snap_fc && !snap_ts;
    end else if (slot == FTCA_SLOT_FC_END) begin
      next_slot  = FTCA_SLOT_TS_HDR;
      slot_final = !snap_ts;
    end else if (slot == FTCA_SLOT_TS_END) begin
      slot_final = 1'b1;
    end
  end

  // Phase control: trailer follows the last image word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= FTCA_IMAGE;
      slot  <= FTCA_SLOT_EXT_HDR;
    end else begin
      case (state)
        FTCA_IMAGE: begin
          if (in_take && in_beat.last && snap_ext_next()) begin
            state <= FTCA_TRAILER;
            slot  <= FTCA_SLOT_EXT_HDR;
          end
        end
        FTCA_TRAILER: begin
          if (load) begin
            slot <= next_slot;
            if (slot_final) begin
              state <= FTCA_IMAGE;
            end
          end
        end
        default: state <= FTCA_IMAGE;
      endcase
    end
  end

  // Chunk decision for a frame: a one-word frame opens and closes at once
  function automatic logic snap_ext_next();
    snap_ext_next = first_word ? trailer_framing_on : snap_ext;
  endfunction

  // Output register: image words, then trailer words, last on final word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_beat  <= '0;
    end else if (load) begin
      if (state == FTCA_TRAILER) begin
        out_valid     <= 1'b1;
        out_beat.data <= slot_word;
        out_beat.last <= slot_final;
      end else begin
        out_valid     <= in_valid;
        out_beat.data <= in_beat.data;
        out_beat.last <= in_beat.last && !snap_ext_next();
      end
    end
  end

endmodule // ftca_appender

// File: tb/ftca_appender_assertions.sv
// Port-level checker of the frame trailer appender
`timescale 1ns/100ps
module ftca_appender_checker import ftca_pkg::*; (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire ftca_beat_s  in_beat,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire ftca_beat_s  out_beat,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [1:0]  payload_kind
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Image word accepted as last of a chunked frame
  wire trl_end = in_valid && in_ready && in_beat.last && payload_kind == FTCA_KIND_TRAILER;
  property p_kind_follows_ctrl;
    psel && penable && pwrite && paddr == FTCA_REG_CTRL |=>
      payload_kind == ($past(pwdata[0]) ? FTCA_KIND_TRAILER : FTCA_KIND_IMAGE);
  endproperty
  a_kind_follows_ctrl: assert property (p_kind_follows_ctrl)
    else $error("payload kind does not follow the master switch");
  property p_pass_through;
    in_valid && in_ready |=> out_valid && out_beat.data == $past(in_beat.data);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("accepted image word not forwarded next cycle");
  property p_hold_stalled;
    out_valid && !out_ready |=> out_valid && $stable(out_beat);
  endproperty
  a_hold_stalled: assert property (p_hold_stalled)
    else $error("stalled output word changed");
  property p_no_overrun;
    in_ready |-> !out_valid || out_ready;
  endproperty
  a_no_overrun: assert property (p_no_overrun)
    else $error("input accepted while output stalled");
  property p_plain_last;
    in_valid && in_ready && in_beat.last && payload_kind == FTCA_KIND_IMAGE |=> out_beat.last;
  endproperty
  a_plain_last: assert property (p_plain_last)
    else $error("plain frame lost its end mark");
  property p_trailer_no_last;
    trl_end |=> out_valid && !out_beat.last;
  endproperty
  a_trailer_no_last: assert property (p_trailer_no_last)
    else $error("end mark on image word of chunked frame");
  property p_trailer_blocks;
    trl_end |=> !in_ready [*7];
  endproperty
  a_trailer_blocks: assert property (p_trailer_blocks)
    else $error("input reopened before extended chunk sent");
  property p_ext_header;
    trl_end |=> ##[1:60] (out_valid && out_beat.data == {FTCA_ID_EXT, FTCA_LEN_EXT});
  endproperty
  a_ext_header: assert property (p_ext_header)
    else $error("extended chunk header missing");
  c_trailer: cover property (trl_end);
  c_stall: cover property (out_valid && !out_ready);
  c_unmapped: cover property (psel && penable && pslverr);
endmodule // ftca_appender_checker

bind ftca_appender ftca_appender_checker u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .in_beat, .in_valid, .in_ready, .out_beat, .out_valid, .out_ready, .payload_kind
);

// File: tb/ftca_host_sink.sv
// Host side model that collects transmitted frame words
`timescale 1ns/100ps
module ftca_host_sink import ftca_pkg::*; (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire ftca_beat_s out_beat,
  input  wire logic       out_valid,
  input  wire logic       stall,
  output logic            out_ready
);
  ftca_beat_s rx_q[$]; // Received words in arrival order
  logic [1:0] cyc;     // Back-pressure phase
  // Refuse two cycles of four while stalling, to exercise output holding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc       <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      cyc       <= cyc + 2'h1;
      out_ready <= !stall || cyc[1];
    end
  end
  // Take a word only at a completed handshake; plain always, the bench empties the queue
  always @(posedge pclk) begin
    if (presetn && out_valid && out_ready) begin
      rx_q.push_back(out_beat);
    end
  end
endmodule // ftca_host_sink

// File: tb/tb_top.sv
// Self-checking bench of the frame trailer appender
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_top import ftca_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  ftca_beat_s  in_beat, out_beat;
  logic        in_valid, in_ready, out_valid, out_ready, stall;
  logic [1:0]  payload_kind;
  int          error_cnt, tests_run, fcnt;
  time         t_rel, t_first, t_a;
  logic [63:0] ts, ts_a, ts_e;
  logic [31:0] exp_q[$];
  // Region, format and range settings, in register order
  logic [31:0] cfg[6] = '{32'h12, 32'h100, 32'h80, 32'h0108_0001, 32'h10, 32'hfff};

  ftca_appender dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_beat(in_beat), .in_valid(in_valid), .in_ready(in_ready),
    .out_beat(out_beat), .out_valid(out_valid), .out_ready(out_ready),
    .payload_kind(payload_kind));
  ftca_host_sink host (.pclk(pclk), .presetn(presetn), .out_beat(out_beat),
    .out_valid(out_valid), .stall(stall), .out_ready(out_ready));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // One APB transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle limit here: the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q     = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd_q)
  endtask
  // Sends one frame and queues its image words as expected output
  task automatic send_frame(input int n, input logic [31:0] base);
    exp_q.delete();
    host.rx_q.delete();
    for (int i = 0; i < n; i++) begin
      in_beat  <= '{data: base + 32'(i), last: (i == n - 1)};
      in_valid <= 1'b1;
      do begin
        @(posedge pclk);
      end while (in_ready !== 1'b1);
      if (i == 0) t_first = $time;
      exp_q.push_back(base + 32'(i));
    end
    in_valid <= 1'b0;
    fcnt++;
  endtask
  // Expected chunks; counter holds frames completed before this one
  task automatic add_trailer(input bit fc, input bit tsn);
    exp_q.push_back({FTCA_ID_EXT, FTCA_LEN_EXT});
    foreach (cfg[i]) exp_q.push_back(cfg[i]);
    if (fc) exp_q.push_back({FTCA_ID_FC, FTCA_LEN_FC});
    if (fc) exp_q.push_back(32'(fcnt - 1));
    if (tsn) exp_q.push_back({FTCA_ID_TS, FTCA_LEN_TS});
  endtask
  // Compares received frame; skip covers the stamp words
  task automatic check_frame(input int skip);
    int k, n;
    n = exp_q.size() + skip;
    k = 0;
    while (host.rx_q.size() < n && k < 500) begin
      @(posedge pclk);
      k++;
    end
    repeat (20) @(posedge pclk);
    `CHK("frame_len", n, host.rx_q.size())
    for (int i = 0; i < n && i < host.rx_q.size(); i++) begin
      if (i < exp_q.size()) `CHK("word", exp_q[i], host.rx_q[i].data)
      `CHK("last", (i == n - 1), host.rx_q[i].last)
    end
    if (skip == 2 && host.rx_q.size() == n) ts = {host.rx_q[n-1].data, host.rx_q[n-2].data};
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests take
  initial begin
    #100us;
    error_cnt++;
    final_report();
  end

  // Main sequence
  initial begin
    {psel, penable, pwrite, in_valid, stall} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    in_beat = '0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_rel = $time;
    rd_chk(FTCA_REG_CTRL, 32'h0, "ctrl_rst");
    `CHK("kind_rst", FTCA_KIND_IMAGE, payload_kind)
    rd_chk(FTCA_REG_TS_HI, 32'h0, "ts_hi");
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, last_err)
    apb(1'b1, FTCA_REG_PICK, 32'h0);
    apb(1'b1, FTCA_REG_ITEM_ON, 32'h1);
    rd_chk(FTCA_REG_ITEM_ON, 32'h0, "item_off");
    send_frame(3, 32'h1000_0000);
    check_frame(0);
    foreach (cfg[i]) apb(1'b1, FTCA_REG_X_START + 8'(4 * i), cfg[i]);
    apb(1'b1, FTCA_REG_CTRL, 32'h1);
    @(posedge pclk); // Switch lands at the access edge, look one edge later
    `CHK("kind_on", FTCA_KIND_TRAILER, payload_kind)
    rd_chk(FTCA_REG_STATUS, {28'h0, FTCA_KIND_TRAILER, FTCA_IMAGE}, "status");
    send_frame(1, 32'h2000_0000);
    add_trailer(1'b0, 1'b0);
    check_frame(0);
    apb(1'b1, FTCA_REG_ITEM_ON, 32'h1);
    rd_chk(FTCA_REG_ITEM_ON, 32'h1, "fc_on");
    apb(1'b1, FTCA_REG_PICK, 32'h1);
    apb(1'b1, FTCA_REG_ITEM_ON, 32'h1);
    stall <= 1'b1;
    send_frame(4, 32'h3000_0000);
    add_trailer(1'b1, 1'b1);
    check_frame(2);
    ts_e = (t_first - t_rel) / FTCA_TICK_NS;
    `CHK("ts_abs", 1'b1, (ts + 2 >= ts_e && ts <= ts_e + 2))
    ts_a = ts;
    t_a = t_first;
    send_frame(2, 32'h4000_0000);
    add_trailer(1'b1, 1'b1);
    check_frame(2);
    ts_e = (t_first - t_a) / FTCA_TICK_NS;
    `CHK("ts_step", 1'b1, (ts - ts_a + 1 >= ts_e && ts - ts_a <= ts_e + 1))
    stall <= 1'b0;
    apb(1'b1, FTCA_REG_FRAME_CNT, 32'hffff);
    rd_chk(FTCA_REG_FRAME_CNT, 32'(fcnt), "fcnt");
    apb(1'b1, FTCA_REG_CTRL, 32'h0);
    @(posedge pclk);
    `CHK("kind_off", FTCA_KIND_IMAGE, payload_kind)
    rd_chk(FTCA_REG_ITEM_ON, 32'h0, "ts_cleared");
    send_frame(2, 32'h5000_0000);
    check_frame(0);
    apb(1'b1, FTCA_REG_CTRL, 32'h1);
    send_frame(1, 32'h6000_0000);
    add_trailer(1'b0, 1'b0);
    check_frame(0);
    final_report();
  end
endmodule // tb_top
